// ==== rtl/vpd_pkg.sv ====
// Constants, types and shared arithmetic for the voice path and tone detector
// Functional notes
// - Run Goertzel terms on eight tones and harmonics; square all sixteen
// - Pick strongest row and column separately, then validate the pair
// - Report digit as row index and column index, sixteen codes
// - One detection pass completes at least twice per 45 ms
// - Accept digit only after two equal passes following a pause
// - Acceptance overwrites the single digit register and raises an event
// - Transmit input is 16-bit linear at 8 kHz
// - Transmit high-pass removes content below 65 Hz before gain; code uses two first-order sections, about 18 dB down at 30 Hz
// - Transmit digital gain spans mute up to 6 dB
// - Detector taps the transmit stream right after transmit gain
// - Transmit ends with optional A-law or mu-law compression to 8 bits
// - Compressed sample uses one slot, linear sample uses two slots
// - Receive expands 8-bit words to 16-bit with selected law
// - Bypass flag joins two received bytes into one 16-bit sample
// - Receive gain mute to 6 dB, then 16-bit samples to D/A
// - Analog transmit and receive gains pick mute, -3.5, 0 or 3.5 dB
// - Three-bit balance trims transhybrid gain around nominal -6 dB
// - Transhybrid term is subtracted before the transmit high-pass and transmit digital gain
// - A register bit switches transhybrid subtraction off
// - Encoder saturates at its maximum code for large inputs
// - Digit event sets pending bit only when its enable is set
// - Writing one clears pending bit; writing zero leaves it
package vpd_pkg;
   localparam int SAMPLE_HZ = 8000;
   localparam int MIN_TONE_MS = 45;
   localparam int PASS_SAMPLES = MIN_TONE_MS * SAMPLE_HZ / 1000 / 2;
   localparam logic [6:0] HYB_OFS = 7'h0b;
   localparam logic [6:0] STATUS_OFS = 7'h13;
   localparam logic [6:0] CTRL_OFS = 7'h16;
   localparam logic [6:0] DIGIT_OFS = 7'h18;
   localparam logic [7:0] HYB_RST = 8'h03;
   localparam logic [7:0] CTRL_RST = 8'h14;
   localparam int HYB_SEL_LSB = 0;
   localparam int HYB_DIS_BIT = 3;
   localparam int CTRL_IRQ_BIT = 0;
   localparam int CTRL_ATX_LSB = 1;
   localparam int CTRL_ARX_LSB = 3;
   localparam int STATUS_DIGIT_BIT = 0;
   localparam int GAIN_FRAC = 14;
   localparam int HYB_FRAC = 12;
   localparam logic [15:0] GAIN_MAX = 16'h8000;
   localparam int HPF_SHIFT = 4;
   localparam int GZ_W = 28;
   localparam int GZ_SHIFT = 6;
   localparam int TWIST_SHIFT = 3;
   localparam int HARM_SHIFT = 3;
   localparam int SEP_SHIFT = 2;
   localparam logic signed [47:0] DET_MIN_ENERGY = 48'sh0000_0400_0000;
   localparam logic [16:0] MU_CLIP = 17'h07f7b;
   localparam logic [16:0] MU_BIAS = 17'h00084;
   typedef enum logic [1:0] {AGAIN_MUTE, AGAIN_M3P5, AGAIN_0DB, AGAIN_P3P5} vpd_again_t;
   typedef enum logic {LAW_MU, LAW_A} vpd_law_t;
   typedef enum logic [1:0] {DET_IDLE, DET_RUN, DET_MAG, DET_EVAL} vpd_det_t;
   // Q14 Goertzel coefficients: 0-3 rows, 4-7 columns, 8-15 second harmonics
   localparam logic [15:0][15:0] GCOEF = {
      16'h94ac, 16'ha8c0, 16'hbf3a, 16'hd6bb, 16'h0bd9, 16'h1d7d, 16'h2d41, 16'h3aa1,
      16'h2460, 16'h3312, 16'h3f9d, 16'h4a81, 16'h5e9b, 16'h6465, 16'h694d, 16'h6d4a};
   // Q12 transhybrid gains, -8.77 dB up to -1.92 dB
   localparam logic [7:0][11:0] HYB_GAIN = {
      12'hcd4, 12'hb75, 12'ha3e, 12'h928, 12'h82e, 12'h74f, 12'h686, 12'h5d3};

   function automatic logic signed [15:0] vpd_sat16(input logic signed [35:0] v);
      if (v > 36'sd32767) begin
         return 16'sh7fff;
      end else if (v < -36'sd32768) begin
         return 16'sh8000;
      end
      return v[15:0];
   endfunction : vpd_sat16

   function automatic logic signed [15:0] vpd_mulq(input logic signed [15:0] x,
                                                    input logic [15:0] g, input int frac);
      logic signed [35:0] p;
      p = (36'(x) * 36'($signed({1'b0, g}))) >>> frac;
      return vpd_sat16(p);
   endfunction : vpd_mulq
endpackage : vpd_pkg

// ==== rtl/vpd_codec.sv ====
// G.711 compressor and expander, combinational
module vpd_codec import vpd_pkg::*; (
   input wire logic law_i,
   input wire logic signed [15:0] enc_lin_i,
   output logic [7:0] enc_code_o,
   input wire logic [7:0] dec_code_i,
   output logic signed [15:0] dec_lin_o
);
   function automatic logic [7:0] mu_enc(input logic signed [15:0] x);
      logic signed [16:0] xs;
      logic [16:0] mag;
      logic [2:0] seg;
      xs = 17'(x);
      mag = (xs < 0) ? 17'(-xs) : 17'(xs);
      if (mag > MU_CLIP) begin
         mag = MU_CLIP;
      end
      mag = mag + MU_BIAS;
      seg = 3'h0;
      for (int i = 0; i < 7; i++) begin
         if (mag[i + 8]) begin
            seg = 3'(i + 1);
         end
      end
      // inversion of all bits, sign set only when positive
      return {1'b0, seg, 4'(mag >> (int'(seg) + 3))} ^ (x[15] ? 8'h7f : 8'hff);
   endfunction : mu_enc

   function automatic logic [7:0] a_enc(input logic signed [15:0] x);
      logic signed [16:0] xs;
      logic [16:0] p;
      logic [2:0] seg;
      logic [3:0] mant;
      xs = 17'(x) >>> 3;
      p = (xs < 0) ? 17'(-xs - 17'sd1) : 17'(xs);
      seg = 3'h0;
      for (int i = 0; i < 7; i++) begin
         if (p >= (17'h00020 << i)) begin
            seg = 3'(i + 1);
         end
      end
      mant = (seg < 3'h2) ? 4'(p >> 1) : 4'(p >> seg);
      // even-bit inversion, sign set for positive
      return {1'b0, seg, mant} ^ (x[15] ? 8'h55 : 8'hd5);
   endfunction : a_enc

   function automatic logic signed [15:0] mu_dec(input logic [7:0] c);
      logic [7:0] u;
      logic [16:0] t;
      u = ~c;
      t = (17'({u[3:0], 3'b000}) + MU_BIAS) << u[6:4];
      return u[7] ? 16'(MU_BIAS - t) : 16'(t - MU_BIAS);
   endfunction : mu_dec

   function automatic logic signed [15:0] a_dec(input logic [7:0] c);
      logic [7:0] a;
      logic [16:0] t;
      a = c ^ 8'h55;
      t = 17'({a[3:0], 4'h0});
      if (a[6:4] == 3'h0) begin
         t = t + 17'h00008;
      end else begin
         t = (t + 17'h00108) << (a[6:4] - 3'h1);
      end
      return a[7] ? 16'(t) : 16'(-t);
   endfunction : a_dec

   assign enc_code_o = (law_i == LAW_A) ? a_enc(enc_lin_i) : mu_enc(enc_lin_i);
   assign dec_lin_o = (law_i == LAW_A) ? a_dec(dec_code_i) : mu_dec(dec_code_i);
endmodule : vpd_codec

// ==== rtl/vpd_fifo.sv ====
// Flip-flop FIFO with valid and ready on both sides
module vpd_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
   } vpd_fifo_st_t;
   vpd_fifo_st_t st;
   vpd_fifo_st_t next_st;
   logic push;
   logic pop;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
   endfunction : bump

   assign in_ready_o = (st.cnt != (AW + 1)'(DEPTH));
   assign out_valid_o = (st.cnt != '0);
   assign out_data_o = st.mem[st.rd];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_comb begin
      next_st = st;
      if (push) begin
         next_st.mem[st.wr] = in_data_i;
         next_st.wr = bump(st.wr);
      end
      if (pop) begin
         next_st.rd = bump(st.rd);
      end
      if (push && !pop) begin
         next_st.cnt = st.cnt + 1'b1;
      end else if (pop && !push) begin
         next_st.cnt = st.cnt - 1'b1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
endmodule : vpd_fifo

// ==== rtl/vpd_voice_path.sv ====
// Voice band transmit and receive path with DTMF digit detector
module vpd_voice_path import vpd_pkg::*; #(
   parameter int FIFO_DEPTH = 16,
   parameter int PASS_LEN = PASS_SAMPLES
) (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic [6:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   input wire logic signed [15:0] adc_sample_i,
   input wire logic adc_valid_i,
   output logic adc_ready_o,
   input wire logic [15:0] tx_digital_gain_i,
   input wire logic [15:0] rx_digital_gain_i,
   input wire logic law_select_i,
   input wire logic companding_bypass_flag_i,
   input wire logic dtmf_enable_i,
   output logic [7:0] pcm_tx_data_o,
   output logic pcm_tx_valid_o,
   input wire logic pcm_tx_ready_i,
   input wire logic [7:0] pcm_rx_data_i,
   input wire logic pcm_rx_valid_i,
   output logic signed [15:0] dac_sample_o,
   output logic dac_valid_o,
   output logic [1:0] analog_tx_gain_select_o,
   output logic [1:0] analog_rx_gain_select_o,
   output logic [3:0] digit_o,
   output logic digit_pending_o,
   output logic digit_event_o
);
   typedef struct packed {
      logic [7:0] hyb;
      logic [7:0] ctrl;
      logic [7:0] rdata;
      logic pending;
      logic [3:0] digit;
      logic event_p;
      logic [1:0][15:0] hpf_x;
      logic [1:0][15:0] hpf_y;
      logic [15:0] tx_lin;
      logic [1:0] push_cnt;
      logic push_raw;
      logic [15:0] dac;
      logic dac_vld;
      logic [7:0] rx_hi;
      logic rx_half;
      vpd_det_t det;
      logic [3:0] idx;
      logic [7:0] nsamp;
      logic [15:0] det_x;
      logic [15:0][GZ_W-1:0] s1;
      logic [15:0][GZ_W-1:0] s2;
      logic [15:0][47:0] en;
      logic armed;
      logic prev_ok;
      logic [3:0] prev_code;
   } vpd_state_t;

   vpd_state_t st;
   vpd_state_t next_st;
   logic [7:0] enc_code;
   logic signed [15:0] dec_lin;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic [7:0] fifo_in_data;

   function automatic logic [15:0] clamp_gain(input logic [15:0] g);
      return (g > GAIN_MAX) ? GAIN_MAX : g;
   endfunction : clamp_gain

   // Squared magnitude s1^2 + s2^2 - c*s1*s2 on prescaled states
   function automatic logic signed [47:0] energy(input logic signed [15:0] c,
                                                 input logic signed [GZ_W-1:0] s1,
                                                 input logic signed [GZ_W-1:0] s2);
      logic signed [47:0] a;
      logic signed [47:0] b;
      a = 48'(s1 >>> GZ_SHIFT);
      b = 48'(s2 >>> GZ_SHIFT);
      return a * a + b * b - (((48'(c) * a) >>> 14) * b);
   endfunction : energy

   vpd_codec u_codec (
      .law_i(law_select_i),
      .enc_lin_i($signed(st.tx_lin)),
      .enc_code_o(enc_code),
      .dec_code_i(pcm_rx_data_i),
      .dec_lin_o(dec_lin)
   );

   // Back-pressure from the highway stalls the pusher and hence the A/D intake
   vpd_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_tx_fifo (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .in_valid_i(fifo_in_valid),
      .in_ready_o(fifo_in_ready),
      .in_data_i(fifo_in_data),
      .out_valid_o(pcm_tx_valid_o),
      .out_ready_i(pcm_tx_ready_i),
      .out_data_o(pcm_tx_data_o)
   );

   // linear words take two slots, high byte first
   assign fifo_in_valid = (st.push_cnt != 2'h0);
   assign fifo_in_data = (st.push_cnt == 2'h2) ? st.tx_lin[15:8] :
                         (st.push_raw ? st.tx_lin[7:0] : enc_code);
   assign adc_ready_o = (st.push_cnt == 2'h0);
   assign reg_rdata_o = st.rdata;
   assign dac_sample_o = $signed(st.dac);
   assign dac_valid_o = st.dac_vld;
   assign analog_tx_gain_select_o = st.ctrl[CTRL_ATX_LSB +: 2];
   assign analog_rx_gain_select_o = st.ctrl[CTRL_ARX_LSB +: 2];
   assign digit_o = st.digit;
   assign digit_pending_o = st.pending;
   assign digit_event_o = st.event_p;

   always_comb begin
      logic take;
      logic rx_done;
      logic ok;
      logic [1:0] r;
      logic [1:0] c;
      logic [3:0] code;
      logic signed [15:0] h;
      logic signed [15:0] v;
      logic signed [15:0] y;
      logic signed [15:0] g;
      logic signed [15:0] lin;
      logic signed [GZ_W-1:0] s0;
      logic signed [47:0] rmax;
      logic signed [47:0] cmax;
      take = 1'b0;
      rx_done = 1'b0;
      ok = 1'b0;
      r = 2'h0;
      c = 2'h0;
      code = 4'h0;
      h = 16'sh0000;
      v = 16'sh0000;
      y = 16'sh0000;
      g = 16'sh0000;
      lin = 16'sh0000;
      s0 = '0;
      rmax = '0;
      cmax = '0;
      next_st = st;
      next_st.dac_vld = 1'b0;
      next_st.event_p = 1'b0;

      if (reg_wr_i) begin
         case (reg_addr_i)
            HYB_OFS: next_st.hyb = reg_wdata_i;
            CTRL_OFS: next_st.ctrl = reg_wdata_i;
            STATUS_OFS: begin
               // write one to clear, zero ignored
               if (reg_wdata_i[STATUS_DIGIT_BIT]) begin
                  next_st.pending = 1'b0;
               end
            end
            default: ;
         endcase
      end
      if (reg_rd_i) begin
         case (reg_addr_i)
            HYB_OFS: next_st.rdata = st.hyb;
            CTRL_OFS: next_st.rdata = st.ctrl;
            STATUS_OFS: next_st.rdata = {7'h00, st.pending};
            DIGIT_OFS: next_st.rdata = {4'h0, st.digit};
            default: next_st.rdata = 8'h00;
         endcase
      end

      take = adc_valid_i && (st.push_cnt == 2'h0);
      // echo estimate from the D/A word, or none when disabled
      if (!st.hyb[HYB_DIS_BIT]) begin
         h = vpd_mulq($signed(st.dac), {4'h0, HYB_GAIN[st.hyb[HYB_SEL_LSB +: 3]]}, HYB_FRAC);
      end
      // subtraction ahead of filter and gain
      v = vpd_sat16(36'(adc_sample_i) - 36'(h));
      // two first-order sections; a limitation: about 18 dB at 30 Hz, not a brick wall
      for (int k = 0; k < 2; k++) begin
         y = vpd_sat16(36'(v) - 36'($signed(st.hpf_x[k])) + 36'($signed(st.hpf_y[k]))
                       - 36'($signed(st.hpf_y[k]) >>> HPF_SHIFT));
         if (take) begin
            next_st.hpf_x[k] = v;
            next_st.hpf_y[k] = y;
         end
         v = y;
      end
      // mute at zero, 0x8000 gives 6 dB
      g = vpd_mulq(v, clamp_gain(tx_digital_gain_i), GAIN_FRAC);
      if (take) begin
         next_st.tx_lin = g;
         next_st.push_cnt = companding_bypass_flag_i ? 2'h2 : 2'h1;
         next_st.push_raw = companding_bypass_flag_i;
         // detector sees the post-gain linear sample
         if (dtmf_enable_i && st.det == DET_IDLE) begin
            next_st.det_x = g;
            next_st.det = DET_RUN;
            next_st.idx = 4'h0;
         end
      end
      if (fifo_in_valid && fifo_in_ready) begin
         next_st.push_cnt = st.push_cnt - 2'h1;
      end

      if (pcm_rx_valid_i) begin
         if (companding_bypass_flag_i) begin
            // high byte first, then low byte completes the word
            if (!st.rx_half) begin
               next_st.rx_hi = pcm_rx_data_i;
               next_st.rx_half = 1'b1;
            end else begin
               lin = $signed({st.rx_hi, pcm_rx_data_i});
               rx_done = 1'b1;
               next_st.rx_half = 1'b0;
            end
         end else begin
            lin = dec_lin;
            rx_done = 1'b1;
            next_st.rx_half = 1'b0;
         end
      end
      if (rx_done) begin
         next_st.dac = vpd_mulq(lin, clamp_gain(rx_digital_gain_i), GAIN_FRAC);
         next_st.dac_vld = 1'b1;
      end

      // Samples arriving while a pass is being scored are skipped; scoring takes 17 cycles
      case (st.det)
         DET_RUN: begin
            // one filter per cycle, sixteen per sample
            s0 = GZ_W'(48'($signed(st.det_x))
                 + ((48'($signed(GCOEF[st.idx])) * 48'($signed(st.s1[st.idx]))) >>> 14)
                 - 48'($signed(st.s2[st.idx])));
            next_st.s2[st.idx] = st.s1[st.idx];
            next_st.s1[st.idx] = s0;
            next_st.idx = st.idx + 4'h1;
            if (st.idx == 4'hf) begin
               next_st.det = DET_IDLE;
               next_st.nsamp = st.nsamp + 8'h01;
               // 180-sample pass, two fit in 45 ms
               if (st.nsamp == 8'(PASS_LEN - 1)) begin
                  next_st.nsamp = 8'h00;
                  next_st.det = DET_MAG;
                  next_st.idx = 4'h0;
               end
            end
         end
         DET_MAG: begin
            // squared magnitudes, states cleared for the next pass
            next_st.en[st.idx] = energy($signed(GCOEF[st.idx]), $signed(st.s1[st.idx]),
                                        $signed(st.s2[st.idx]));
            next_st.s1[st.idx] = '0;
            next_st.s2[st.idx] = '0;
            next_st.idx = st.idx + 4'h1;
            if (st.idx == 4'hf) begin
               next_st.det = DET_EVAL;
            end
         end
         DET_EVAL: begin
            // strongest row and column picked apart
            for (int j = 1; j < 4; j++) begin
               if ($signed(st.en[j]) > $signed(st.en[r])) begin
                  r = 2'(j);
               end
               if ($signed(st.en[j + 4]) > $signed(st.en[4 + int'(c)])) begin
                  c = 2'(j);
               end
            end
            rmax = $signed(st.en[r]);
            cmax = $signed(st.en[4 + int'(c)]);
            // level, twist and harmonic checks on the pair
            ok = (rmax >= DET_MIN_ENERGY) && (cmax >= DET_MIN_ENERGY)
                 && ((rmax <<< TWIST_SHIFT) >= cmax) && ((cmax <<< TWIST_SHIFT) >= rmax)
                 && (($signed(st.en[8 + int'(r)]) <<< HARM_SHIFT) < rmax)
                 && (($signed(st.en[12 + int'(c)]) <<< HARM_SHIFT) < cmax);
            for (int j = 0; j < 4; j++) begin
               if (j != int'(r) && ($signed(st.en[j]) <<< SEP_SHIFT) > rmax) begin
                  ok = 1'b0;
               end
               if (j != int'(c) && ($signed(st.en[j + 4]) <<< SEP_SHIFT) > cmax) begin
                  ok = 1'b0;
               end
            end
            // code is row then column index
            code = {r, c};
            if (ok) begin
               // two matching passes after a pause
               if (st.prev_ok && st.prev_code == code && st.armed) begin
                  next_st.digit = code;
                  next_st.event_p = 1'b1;
                  next_st.armed = 1'b0;
                  // pending only when enabled; set beats a same-cycle clear
                  if (st.ctrl[CTRL_IRQ_BIT]) begin
                     next_st.pending = 1'b1;
                  end
               end
            end else begin
               next_st.armed = 1'b1;
            end
            next_st.prev_ok = ok;
            next_st.prev_code = code;
            next_st.det = DET_IDLE;
         end
         default: begin
            // Disabled detector drops partial passes so a restart begins clean
            if (!dtmf_enable_i) begin
               next_st.nsamp = 8'h00;
               next_st.s1 = '0;
               next_st.s2 = '0;
               next_st.armed = 1'b1;
               next_st.prev_ok = 1'b0;
            end
            // No state assignment here: a take this cycle has already started a run
         end
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         st <= '0;
         st.hyb <= HYB_RST;
         st.ctrl <= CTRL_RST;
         st.armed <= 1'b1;
      end else begin
         st <= next_st;
      end
   end
endmodule : vpd_voice_path

// ==== tb/vpd_voice_path_chk.sv ====
// Port-level assertions for the voice path top
module vpd_voice_path_chk (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic reg_wr_i,
   input wire logic adc_valid_i,
   input wire logic adc_ready_o,
   input wire logic companding_bypass_flag_i,
   input wire logic pcm_tx_valid_o,
   input wire logic pcm_tx_ready_i,
   input wire logic pcm_rx_valid_i,
   input wire logic signed [15:0] dac_sample_o,
   input wire logic dac_valid_o,
   input wire logic [1:0] analog_tx_gain_select_o,
   input wire logic [1:0] analog_rx_gain_select_o,
   input wire logic [3:0] digit_o,
   input wire logic digit_pending_o,
   input wire logic digit_event_o
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   gain_hold_a: assert property (!reg_wr_i |=> $stable(analog_tx_gain_select_o))
      else $error("analog gain moved without a write");
   pend_set_a: assert property ($rose(digit_pending_o)
      |-> digit_event_o || $past(digit_event_o))
      else $error("pending set without a digit event");
   pend_clear_a: assert property ($fell(digit_pending_o) |-> $past(reg_wr_i))
      else $error("pending cleared without a write");
   digit_load_a: assert property ($changed(digit_o)
      |-> digit_event_o || $past(digit_event_o))
      else $error("digit changed without acceptance");
   event_pulse_a: assert property (digit_event_o |=> !digit_event_o)
      else $error("digit event longer than one cycle");
   rx_expand_a: assert property (pcm_rx_valid_i && !companding_bypass_flag_i
      |=> dac_valid_o)
      else $error("expanded sample missing");
   dac_hold_a: assert property (!dac_valid_o |-> $stable(dac_sample_o))
      else $error("dac sample moved without valid");
   tx_first_a: assert property (adc_valid_i && adc_ready_o && !pcm_tx_valid_o
      |-> ##2 pcm_tx_valid_o)
      else $error("transmit byte late");
   tx_hold_a: assert property (pcm_tx_valid_o && !pcm_tx_ready_i |=> pcm_tx_valid_o)
      else $error("transmit byte dropped while stalled");
   digit_c: cover property (digit_event_o);
   pair_c: cover property (companding_bypass_flag_i && pcm_rx_valid_i ##[1:4] dac_valid_o);
   stall_c: cover property (adc_valid_i && !adc_ready_o);
endmodule : vpd_voice_path_chk

// ==== tb/vpd_highway_model.sv ====
// Highway host model: drains transmit bytes, stalls on request
module vpd_highway_model (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic stall_i,
   input wire logic tx_valid_i,
   input wire logic [7:0] tx_data_i,
   output logic tx_ready_o,
   output int pop_count_o,
   output logic [7:0] last_byte_o
);
   timeunit 1ns;
   timeprecision 100ps;
   assign tx_ready_o = !stall_i;
   always @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         pop_count_o <= 0;
      end else if (tx_valid_i && tx_ready_o) begin
         pop_count_o <= pop_count_o + 1;
         last_byte_o <= tx_data_i;
      end
   end
endmodule : vpd_highway_model

// ==== tb/vpd_voice_path_test.sv ====
// Self-checking bench for the voice path top
module vpd_voice_path_test import vpd_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk_i = 0, sys_rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, adc_valid_i = 0, stall = 0;
   logic law_select_i = 0, companding_bypass_flag_i = 0, dtmf_enable_i = 0, pcm_rx_valid_i = 0;
   logic [6:0] reg_addr_i = 0;
   logic [7:0] reg_wdata_i = 0, pcm_rx_data_i = 0, pcm_tx_data_o, reg_rdata_o, last_byte;
   logic signed [15:0] adc_sample_i = 0, dac_sample_o;
   logic [15:0] tx_digital_gain_i = 0, rx_digital_gain_i = 16'h4000;
   logic adc_ready_o, pcm_tx_valid_o, pcm_tx_ready_i, dac_valid_o, digit_pending_o, digit_event_o;
   logic [1:0] analog_tx_gain_select_o, analog_rx_gain_select_o;
   logic [3:0] digit_o;
   int n_mismatch = 0, check_count = 0, pops, base, ev_count = 0, i;
   // Law, gain, code and expected linear value
   localparam logic [40:0] RXT [6] = '{{1'b0, 16'h4000, 8'hff, 16'h0000},
      {1'b0, 16'h4000, 8'h80, 16'h7d7c}, {1'b1, 16'h4000, 8'hd5, 16'h0008},
      {1'b1, 16'h4000, 8'haa, 16'h7e00}, {1'b1, 16'h8000, 8'hd5, 16'h0010},
      {1'b0, 16'h0000, 8'h80, 16'h0000}};
   vpd_voice_path dut_u (.*);
   vpd_highway_model host_u (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .stall_i(stall),
      .tx_valid_i(pcm_tx_valid_o), .tx_data_i(pcm_tx_data_o), .tx_ready_o(pcm_tx_ready_i),
      .pop_count_o(pops), .last_byte_o(last_byte));
   initial begin
      forever #2.5 core_clk_i = ~core_clk_i;
   end
   // Events are single-cycle pulses, so count them as they pass
   always @(posedge core_clk_i) begin
      if (digit_event_o === 1'b1) begin
         ev_count <= ev_count + 1;
      end
   end
   task automatic tick(input int n = 1);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask : tick
   task automatic cmp(input logic [15:0] g, input logic [15:0] e);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got %h expected %h", $time, g, e);
      end
   endtask : cmp
   task automatic give_verdict;
      $display("mismatches %0d checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : give_verdict
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1;
      tick();
      reg_wr_i = 0;
      tick();
   endtask : wr
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      reg_addr_i = a;
      reg_rd_i = 1;
      tick();
      reg_rd_i = 0;
      tick();
      cmp(reg_rdata_o, e);
   endtask : rd
   task automatic rx(input logic [7:0] b);
      pcm_rx_data_i = b;
      pcm_rx_valid_i = 1;
      tick();
      pcm_rx_valid_i = 0;
      tick();
   endtask : rx
   task automatic tx(input logic signed [15:0] s);
      int k;
      for (k = 0; k < 200 && adc_ready_o !== 1'b1; k++) tick();
      if (k == 200) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t adc ready timeout", $time);
         give_verdict();
      end
      adc_sample_i = s;
      adc_valid_i = 1;
      tick();
      adc_valid_i = 0;
      tick();
   endtask : tx
   initial begin
      tick(6);
      sys_rst_i = 0;
      rd(HYB_OFS, HYB_RST);
      rd(CTRL_OFS, CTRL_RST);
      rd(7'h7f, 8'h00);
      for (i = 0; i < 4; i++) begin
         wr(CTRL_OFS, 8'(i * 10));
         cmp({analog_rx_gain_select_o, analog_tx_gain_select_o}, 16'(i * 5));
      end
      wr(CTRL_OFS, 8'h15);
      wr(HYB_OFS, 8'h0b);
      rd(HYB_OFS, 8'h0b);
      for (i = 0; i < 6; i++) begin
         {law_select_i, rx_digital_gain_i} = RXT[i][40:24];
         rx(RXT[i][23:16]);
         cmp(dac_sample_o, RXT[i][15:0]);
      end
      rx_digital_gain_i = 16'h4000;
      companding_bypass_flag_i = 1;
      rx(8'h12);
      cmp(dac_sample_o, 16'h0000);
      rx(8'h34);
      cmp(dac_sample_o, 16'h1234);
      // Muted gain after subtraction must give silence in every mode
      for (i = 0; i < 3; i++) begin
         {companding_bypass_flag_i, law_select_i} = 2'(i);
         base = pops;
         tx(16'sh1234);
         tick(4);
         cmp(16'(pops - base), (i == 2) ? 16'h2 : 16'h1);
         cmp(last_byte, (i == 0) ? 8'hff : ((i == 1) ? 8'hd5 : 8'h00));
      end
      // Compressed mode, so sixteen samples fill the FIFO and the seventeenth waits
      companding_bypass_flag_i = 0;
      stall = 1;
      base = pops;
      for (i = 0; i < 17; i++) tx(16'sh0100);
      tick(3);
      cmp(adc_ready_o, 1'b0);
      stall = 0;
      tick(40);
      cmp(16'(pops - base), 16'd17);
      cmp(pcm_tx_valid_o, 1'b0);
      // Over-range gain clamps to 6 dB and drives the encoder into its top code
      tx_digital_gain_i = 16'hffff;
      for (i = 0; i < 2; i++) begin
         law_select_i = i[0];
         tx(16'sh7fff);
         tick(4);
         cmp(last_byte, (i == 0) ? 8'h80 : 8'haa);
      end
      tx_digital_gain_i = 16'h4000;
      dtmf_enable_i = 1;
      for (i = 0; i < PASS_SAMPLES * 6; i++) begin
         tx((i < PASS_SAMPLES * 2) ? 16'sh0 : 16'($rtoi(8000.0 * ($sin(6.2831853 * 852.0 * i
            / 8000.0) + $sin(6.2831853 * 1633.0 * i / 8000.0)))));
         tick(40);
      end
      cmp(16'(ev_count), 16'd1);
      cmp(digit_o, 4'hb);
      rd(DIGIT_OFS, 8'h0b);
      cmp(digit_pending_o, 1'b1);
      wr(STATUS_OFS, 8'h00);
      cmp(digit_pending_o, 1'b1);
      wr(STATUS_OFS, 8'h01);
      cmp(digit_pending_o, 1'b0);
      give_verdict();
   end
endmodule : vpd_voice_path_test
bind vpd_voice_path vpd_voice_path_chk chk_u (.*);
